// ===== common/smr_map.vh
// timing counts, encodings and reset values of the supply monitor reset logic
`ifndef SMR_MAP_VH
`define SMR_MAP_VH
`define SMR_CLK_HZ          20000000
`define SMR_TMO_INT_MS      200
`define SMR_TMO_MIN_US      400
`define SMR_TMO_EXT_MS      20
`define SMR_CYC_INT         (`SMR_CLK_HZ / 1000 * `SMR_TMO_INT_MS)
`define SMR_CYC_MIN         (`SMR_CLK_HZ / 1000000 * `SMR_TMO_MIN_US)
`define SMR_CYC_EXT         (`SMR_CLK_HZ / 1000 * `SMR_TMO_EXT_MS)
`define SMR_CNT_W           32
`define SMR_SEL_HIGH        2'h2
`define SMR_SEL_OPEN        2'h1
`define SMR_SEL_GND         2'h0
`define SMR_TMR_CAP         2'h0
`define SMR_TMR_OPEN        2'h1
`define SMR_TMR_GND         2'h2
`define SMR_TMR_VCC         2'h3
`define SMR_OFF_STATUS      4'h0
`define SMR_OFF_ENABLE      4'h4
`define SMR_OFF_CLEAR       4'h8
`define SMR_OFF_STATE       4'hc
`define SMR_EV_W            4
`define SMR_RST_STATUS      4'h0
`endif

// ===== design/smr_timer.v
// reset timeout counter that restarts from zero whenever it is cleared
module smr_timer #(
    parameter CW = 32
) (
    input  wire          clk,
    input  wire          rst_b,
    input  wire          run,
    input  wire [CW-1:0] limit,
    output reg           done
);
    reg [CW-1:0] count;
    always @(posedge clk) begin
        if (!rst_b) begin
            count <= {CW{1'b0}};
            done  <= 1'b0;
        end else if (!run) begin
            count <= {CW{1'b0}};
            done  <= 1'b0;
        end else if (count >= limit) begin
            done  <= 1'b1;
        end else begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // smr_timer

// ===== design/smr_top.v
// supply monitor decision and reset timing logic with avalon-mm status registers
`include "smr_map.vh"
module smr_top #(
    parameter CW      = `SMR_CNT_W,
    parameter CYC_INT = `SMR_CYC_INT,
    parameter CYC_MIN = `SMR_CYC_MIN,
    parameter CYC_EXT = `SMR_CYC_EXT
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [1:0]  polarity_select,
    input  wire [1:0]  timeout_control,
    input  wire        above_thr_one,
    input  wire        above_thr_two,
    input  wire        supply_ok,
    input  wire [CW-1:0] ext_timeout_cycles,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         status_output_one_oe,
    output reg         status_output_two_oe,
    output reg         reset_output_n_oe,
    output reg         irq
);
    localparam ST_LOCK = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_RUN  = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg       pol_one;
    reg       pol_two;
    reg [1:0] tmr_mode;
    reg [`SMR_EV_W-1:0] status;
    reg [`SMR_EV_W-1:0] enable;
    reg       prev_rst_n;
    reg       prev_one;
    reg       prev_sup;
    reg       acc_done;
    wire      valid_one;
    wire      valid_two;
    wire      all_valid;
    wire      timer_done;
    wire      timer_run;
    wire [1:0] above_vec;
    wire [1:0] pol_vec;
    wire [1:0] valid_vec;
    reg [CW-1:0] limit;

    // polarity bit 1 means positive; unknown codes fall back to both negative
    function [1:0] decode_pol;
        input [1:0] sel;
        begin
            case (sel)
                `SMR_SEL_HIGH: decode_pol = 2'b11;
                `SMR_SEL_OPEN: decode_pol = 2'b10;
                `SMR_SEL_GND:  decode_pol = 2'b00;
                default:       decode_pol = 2'b00;
            endcase
        end
    endfunction

    function valid_for;
        input pos;
        input above;
        begin
            valid_for = pos ? above : ~above;
        end
    endfunction

    // channel 0 is input one, channel 1 is input two
    assign above_vec = {above_thr_two, above_thr_one};
    assign pol_vec   = {pol_two, pol_one};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            assign valid_vec[ch] = valid_for(pol_vec[ch], above_vec[ch]);
        end
    endgenerate

    assign valid_one = valid_vec[0];
    assign valid_two = valid_vec[1];
    assign all_valid = valid_one & valid_two & supply_ok & (state != ST_LOCK);

    // capacitor period arrives as a cycle count; zero falls back to the 20ms default at 2.2nF
    function [CW-1:0] pick_limit;
        input [1:0]    mode;
        input [CW-1:0] ext_cyc;
        begin
            case (mode)
                `SMR_TMR_CAP: begin
                    if (ext_cyc == {CW{1'b0}})
                        pick_limit = CYC_EXT[CW-1:0];
                    else
                        pick_limit = ext_cyc;
                end
                `SMR_TMR_OPEN: pick_limit = CYC_MIN[CW-1:0];
                `SMR_TMR_GND:  pick_limit = CYC_INT[CW-1:0];
                default:       pick_limit = {CW{1'b0}};
            endcase
        end
    endfunction

    always @* begin
        limit = pick_limit(tmr_mode, ext_timeout_cycles);
    end

    // timer only counts in run with every input valid, so any fault clears it
    assign timer_run = (state == ST_RUN) & all_valid;

    smr_timer #(.CW(CW)) u_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (timer_run),
        .limit (limit),
        .done  (timer_done)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_LOCK: begin
                if (supply_ok)
                    next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (!supply_ok)
                    next_state = ST_LOCK;
                else if (valid_one && valid_two)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!supply_ok)
                    next_state = ST_LOCK;
                else if (!(valid_one && valid_two))
                    next_state = ST_WAIT;
            end
            default: begin
                next_state = ST_LOCK;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            state    <= ST_LOCK;
            pol_one  <= 1'b0;
            pol_two  <= 1'b0;
            tmr_mode <= `SMR_TMR_GND;
        end else begin
            state <= next_state;
            // settings latched once at lockout release, as the pins are straps
            if (state == ST_LOCK && supply_ok) begin
                {pol_one, pol_two} <= decode_pol(polarity_select);
                tmr_mode           <= timeout_control;
            end
        end
    end

    // outputs: oe high means the pin is pulled low
    always @(posedge clk) begin
        if (!rst_b) begin
            status_output_one_oe <= 1'b1;
            status_output_two_oe <= 1'b1;
            reset_output_n_oe    <= 1'b1;
        end else if (state == ST_LOCK || !supply_ok) begin
            status_output_one_oe <= 1'b1;
            status_output_two_oe <= 1'b1;
            reset_output_n_oe    <= 1'b1;
        end else begin
            status_output_one_oe <= ~valid_one;
            status_output_two_oe <= ~valid_two;
            if (tmr_mode == `SMR_TMR_VCC) begin
                // comparator mode: no timer, reset follows the inputs
                reset_output_n_oe <= ~(valid_one & valid_two);
            end else if (!(valid_one && valid_two)) begin
                reset_output_n_oe <= 1'b1;
            end else begin
                reset_output_n_oe <= ~(state == ST_RUN && timer_done);
            end
        end
    end

    // events: bit0 reset released, bit1 reset asserted, bit2 output one went low, bit3 supply lost
    // edges of the registered outputs and of the supply_ok input, so a held level sets its bit only once
    wire                 ev_released;
    wire                 ev_asserted;
    wire                 ev_fault_one;
    wire                 ev_sup_lost;
    wire [`SMR_EV_W-1:0] ev;
    assign ev_released  = prev_rst_n & ~reset_output_n_oe;
    assign ev_asserted  = ~prev_rst_n & reset_output_n_oe;
    assign ev_fault_one = ~prev_one & status_output_one_oe;
    assign ev_sup_lost  = prev_sup & ~supply_ok;
    assign ev = {ev_sup_lost, ev_fault_one, ev_asserted, ev_released};

    // a write commits only in the cycle waitrequest stands low; the master holds it until then
    wire wr_go;
    wire acc_go;
    assign wr_go  = avs_write & acc_done;
    assign acc_go = (avs_read | avs_write) & ~acc_done;

    // unmapped offsets read as zero
    function [31:0] read_word;
        input [3:0] addr;
        begin
            case (addr)
                `SMR_OFF_STATUS: read_word = {{(32-`SMR_EV_W){1'b0}}, status};
                `SMR_OFF_ENABLE: read_word = {{(32-`SMR_EV_W){1'b0}}, enable};
                `SMR_OFF_STATE:  read_word = {{22{1'b0}}, tmr_mode, pol_one, pol_two, state,
                                              status_output_one_oe, status_output_two_oe,
                                              reset_output_n_oe};
                default:         read_word = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (!rst_b) begin
            status     <= `SMR_RST_STATUS;
            enable     <= {`SMR_EV_W{1'b0}};
            prev_rst_n <= 1'b1;
            prev_one   <= 1'b1;
            prev_sup   <= 1'b0;
            irq        <= 1'b0;
        end else begin
            prev_rst_n <= reset_output_n_oe;
            prev_one   <= status_output_one_oe;
            prev_sup   <= supply_ok;
            // set wins over a clear in the same cycle
            if (wr_go && avs_address == `SMR_OFF_CLEAR)
                status <= (status & ~avs_writedata[`SMR_EV_W-1:0]) | ev;
            else
                status <= status | ev;
            if (wr_go && avs_address == `SMR_OFF_ENABLE)
                enable <= avs_writedata[`SMR_EV_W-1:0];
            irq <= |((status | ev) & enable);
        end
    end

    // one wait cycle per access; unmapped reads return zero, writes ignored
    always @(posedge clk) begin
        if (!rst_b) begin
            acc_done        <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (acc_done) begin
            acc_done        <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else if (acc_go) begin
            acc_done        <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= read_word(avs_address);
        end
    end
endmodule // smr_top

// ===== sim/smr_supply.sv
// partner model: monitored supplies and their comparator results
module smr_supply (
    input  logic clk,
    input  logic lvl_one,
    input  logic lvl_two,
    input  logic unused_one,
    input  logic unused_two,
    input  logic sup_on,
    output logic above_thr_one,
    output logic above_thr_two,
    output logic supply_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    // registered, so a level change lands one clock after the bench sets it
    always @(posedge clk) begin
        above_thr_one <= unused_one ? 1'b1 : lvl_one;
        above_thr_two <= unused_two ? 1'b0 : lvl_two;
        supply_ok     <= sup_on;
    end
endmodule // smr_supply

// ===== sim/smr_top_assertions.sv
// concurrent checks on the supply monitor port behaviour
`include "smr_map.vh"
module smr_chk #(parameter CW = 32, CYC_INT = 20, CYC_MIN = 8, CYC_EXT = 12) (
    input logic          clk,
    input logic          rst_b,
    input logic [1:0]    polarity_select,
    input logic [1:0]    timeout_control,
    input logic          above_thr_one,
    input logic          above_thr_two,
    input logic          supply_ok,
    input logic [CW-1:0] ext_timeout_cycles,
    input logic          avs_read,
    input logic          avs_write,
    input logic          avs_waitrequest,
    input logic          status_output_one_oe,
    input logic          status_output_two_oe,
    input logic          reset_output_n_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic v1, v2, cmp;
    int   ok, lo, run, lim;
    assign v1  = above_thr_one ^ (polarity_select == `SMR_SEL_GND || polarity_select == 2'h3);
    assign v2  = above_thr_two ^ (polarity_select != `SMR_SEL_HIGH);
    assign cmp = timeout_control == `SMR_TMR_VCC;
    assign lim = timeout_control == `SMR_TMR_OPEN ? CYC_MIN : timeout_control == `SMR_TMR_GND ? CYC_INT :
                 ext_timeout_cycles == 0 ? CYC_EXT : int'(ext_timeout_cycles);
    // settle margin: latch edge plus output register after lockout release
    always @(posedge clk) begin
        ok  <= (rst_b && supply_ok) ? (ok < 4 ? ok + 1 : 4) : 0;
        lo  <= (rst_b && !supply_ok) ? (lo < 3 ? lo + 1 : 3) : 0;
        run <= (rst_b && supply_ok && v1 && v2) ? run + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    out_one_a: assert property (ok == 4 |-> status_output_one_oe == !$past(v1))
        else $error("status one wrong");
    out_two_a: assert property (ok == 4 |-> status_output_two_oe == !$past(v2))
        else $error("status two wrong");
    rst_bad_a: assert property (ok == 4 && !$past(v1 && v2) |-> reset_output_n_oe)
        else $error("reset not held");
    lock_low_a: assert property (lo == 3 |-> reset_output_n_oe && status_output_one_oe && status_output_two_oe)
        else $error("outputs free in lockout");
    cmp_mode_a: assert property (ok == 4 && cmp |-> reset_output_n_oe == !$past(v1 && v2))
        else $error("comparator mode wrong");
    early_rel_a: assert property (ok == 4 && !cmp && !reset_output_n_oe |-> run >= lim)
        else $error("reset released early");
    late_rel_a: assert property (ok == 4 && !cmp && run == lim + 8 |-> !reset_output_n_oe)
        else $error("reset released late");
    bus_ans_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule // smr_chk
bind smr_top smr_chk #(.CW(CW), .CYC_INT(CYC_INT), .CYC_MIN(CYC_MIN), .CYC_EXT(CYC_EXT)) chk_u (
    .clk, .rst_b, .polarity_select, .timeout_control, .above_thr_one, .above_thr_two, .supply_ok,
    .ext_timeout_cycles, .avs_read, .avs_write, .avs_waitrequest, .status_output_one_oe,
    .status_output_two_oe, .reset_output_n_oe);

// ===== sim/tb_supply_monitor_reset_logic.sv
// self-checking bench for the supply monitor reset logic
`include "smr_map.vh"
module tb_supply_monitor_reset_logic;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_b = 0, lv1 = 0, lv2 = 0, sup = 0, wr = 0, rd = 0, un1 = 0, un2 = 0;
    logic        a1, a2, sok, wt, irq, o1, o2, orst;
    logic [1:0]  sel = 0, tmr = 0;
    logic [3:0]  adr = 0;
    logic [31:0] wd = 0, ext = 0, rdata, q;
    int          err_total = 0, num_checks = 0, cyc = 0;
    // rows: select, timeout mode, two levels, then expected status one, status two, reset
    logic [8:0]  rows [8] = '{9'h118, 9'h12d, 9'h0d0, 9'h0fb, 9'h060, 9'h015, 9'h1a0, 9'h1cb};
    smr_supply sup_u (.clk, .lvl_one(lv1), .lvl_two(lv2), .unused_one(un1), .unused_two(un2),
                      .sup_on(sup), .above_thr_one(a1), .above_thr_two(a2), .supply_ok(sok));
    smr_top #(.CYC_INT(20), .CYC_MIN(8), .CYC_EXT(12)) dut_u (.clk, .rst_b, .polarity_select(sel),
        .timeout_control(tmr), .above_thr_one(a1), .above_thr_two(a2), .supply_ok(sok),
        .ext_timeout_cycles(ext), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdata), .avs_waitrequest(wt), .status_output_one_oe(o1),
        .status_output_two_oe(o2), .reset_output_n_oe(orst), .irq);
    always #25 clk = ~clk;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        if (s !== e) begin
            $display("[ERR] %s exp %h seen %h", n, e, s);
            err_total++;
        end
        num_checks++;
    endtask
    // holds the request until waitrequest is sampled low, then one idle edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdata;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        chk("reset outs", {o1, o2, orst, irq, wt}, 5'h1d);
        foreach (rows[i]) begin
            rst_b <= 0;
            sup <= 0;
            {sel, tmr, lv1, lv2} <= rows[i][8:3];
            @(posedge clk);
            rst_b <= 1;
            sup <= 1;
            repeat (40) @(posedge clk);
            chk("outs", {o1, o2, orst}, rows[i][2:0]);
            $display("row %0d done", i);
        end
        {lv1, lv2} <= 2'b00;
        repeat (12) @(posedge clk);
        lv1 <= 1;
        repeat (2) @(posedge clk);
        lv1 <= 0;
        repeat (16) @(posedge clk);
        chk("restart", orst, 1);
        repeat (16) @(posedge clk);
        chk("release", orst, 0);
        bus(1, `SMR_OFF_CLEAR, 32'hf);
        bus(1, `SMR_OFF_ENABLE, 32'h1);
        bus(0, `SMR_OFF_ENABLE, 32'h0);
        chk("enable", q, 1);
        chk("irq idle", irq, 0);
        sup <= 0;
        repeat (5) @(posedge clk);
        chk("brownout", {o1, o2, orst}, 3'h7);
        sup <= 1;
        repeat (40) @(posedge clk);
        chk("irq set", irq, 1);
        bus(0, `SMR_OFF_STATUS, 32'h0);
        chk("status", q & 32'h1, 1);
        bus(1, `SMR_OFF_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 0);
        bus(1, `SMR_OFF_CLEAR, 32'h1);
        bus(0, `SMR_OFF_STATUS, 32'h0);
        chk("cleared", q & 32'h1, 0);
        bus(0, 4'h2, 32'h0);
        chk("unmapped", q, 0);
        // capacitor mode with a short programmed count; the default would still hold reset here
        ext <= 32'h5;
        {sel, tmr, lv1, lv2} <= 6'h23;
        rst_b <= 0;
        @(posedge clk);
        rst_b <= 1;
        repeat (12) @(posedge clk);
        chk("cap cycles", orst, 0);
        // unused inputs tied off so they read valid, select open, comparator mode
        {un1, un2, lv1, lv2} <= 4'hd;
        {sel, tmr} <= 4'h7;
        rst_b <= 0;
        @(posedge clk);
        rst_b <= 1;
        repeat (8) @(posedge clk);
        chk("unused ties", {o1, o2, orst}, 3'h0);
        $display("hand tests done");
        results();
    end
endmodule // tb_supply_monitor_reset_logic
